// ===== core/pma_pkg.sv
package pma_pkg;

  // ****************************
  // array geometry
  // ****************************
  localparam int NUM_MC     = 64;
  localparam int MC_PER_REG = 4;
  localparam int MC_PER_BLK = 16;
  localparam int NUM_PT     = 5;
  localparam int SW_W       = 40;
  localparam int N_IN       = 4;
  localparam int N_GCK      = 3;
  localparam int N_OEP      = 2;
  localparam int PT_IN      = SW_W + MC_PER_REG;
  localparam int PT_MW      = 2 * PT_IN;
  localparam int CFG_W      = 64;
  localparam int PTI_W      = 3;
  localparam int GBI_W      = 8;
  localparam int MCI_W      = 6;

  // ****************************
  // macrocell word fields
  // ****************************
  localparam int F_OR_MASK  = 0;
  localparam int F_CAS_EN   = 5;
  localparam int F_XOR_MODE = 6;
  localparam int F_XOR_PT   = 8;
  localparam int F_D_SEL    = 11;
  localparam int F_D_PT     = 13;
  localparam int F_FF_MODE  = 16;
  localparam int F_K_PT     = 19;
  localparam int F_CLK_SEL  = 22;
  localparam int F_CLK_PT   = 24;
  localparam int F_CE_EN    = 27;
  localparam int F_CE_PT    = 28;
  localparam int F_AR_SEL   = 31;
  localparam int F_AR_PT    = 33;
  localparam int F_AP_EN    = 36;
  localparam int F_AP_PT    = 37;
  localparam int F_OUT_REG  = 40;
  localparam int F_FB_REG   = 41;
  localparam int F_IO_MODE  = 42;
  localparam int F_OE_SRC   = 44;
  localparam int F_OE_IDX   = 46;
  localparam int F_OE_INV   = 52;
  localparam int F_FOLD_PT  = 53;

  // ****************************
  // field encodings
  // ****************************
  localparam logic [1:0] XOR_ZERO = 2'h0;
  localparam logic [1:0] XOR_ONE  = 2'h1;
  localparam logic [1:0] XOR_PT   = 2'h2;
  localparam logic [1:0] D_XOR    = 2'h0;
  localparam logic [1:0] D_PT     = 2'h1;
  localparam logic [1:0] D_PIN    = 2'h2;
  localparam logic [2:0] FF_D     = 3'h0;
  localparam logic [2:0] FF_T     = 3'h1;
  localparam logic [2:0] FF_JK    = 3'h2;
  localparam logic [2:0] FF_SR    = 3'h3;
  localparam logic [2:0] FF_LATCH = 3'h4;
  localparam logic [1:0] CLK_PT   = 2'h3;
  localparam logic [1:0] AR_OFF   = 2'h0;
  localparam logic [1:0] AR_GCLR  = 2'h1;
  localparam logic [1:0] AR_PT    = 2'h2;
  localparam logic [1:0] AR_BOTH  = 2'h3;
  localparam logic [1:0] IO_IN    = 2'h0;
  localparam logic [1:0] IO_OUT   = 2'h1;
  localparam logic [1:0] IO_BIDIR = 2'h2;
  localparam logic [1:0] OE_PIN   = 2'h0;
  localparam logic [1:0] OE_IO    = 2'h1;
  localparam logic [1:0] OE_MC    = 2'h2;

  // ****************************
  // register map
  // ****************************
  localparam logic [7:0]  R_SIGN   = 8'h00;
  localparam logic [7:0]  R_FUSE   = 8'h04;
  localparam logic [7:0]  R_CIDX   = 8'h08;
  localparam logic [7:0]  R_CLO    = 8'h0c;
  localparam logic [7:0]  R_CHI    = 8'h10;
  localparam logic [7:0]  R_QLO    = 8'h14;
  localparam logic [7:0]  R_QHI    = 8'h18;
  localparam logic [15:0] SIGN_RST = 16'h0000;

endpackage

// ===== core/pma_macrocell_array.sv
// Decided for this implementation: the AHB-Lite register port and the placing of the registers.
`timescale 1ns/1ns
module pma_macrocell_array #(
  parameter int                                  NMC    = pma_pkg::NUM_MC,
  parameter logic [NMC*pma_pkg::CFG_W-1:0]       MC_CFG = '0,
  parameter logic [NMC*pma_pkg::NUM_PT*pma_pkg::PT_MW-1:0]
                                                 PT_CFG = '0,
  parameter logic [NMC/pma_pkg::MC_PER_BLK*pma_pkg::SW_W*pma_pkg::GBI_W-1:0]
                                                 SW_SEL = '0,
  parameter bit                                  KEEPER = 1'b0
) (
  input  wire logic                        clock,
  input  wire logic                        rst,
  input  wire logic [pma_pkg::N_IN-1:0]    inPins,
  input  wire logic [pma_pkg::N_GCK-1:0]   globalClockLines,
  input  wire logic                        globalClearLine,
  input  wire logic [pma_pkg::N_OEP-1:0]   oePins,
  input  wire logic [NMC-1:0]              ioIn,
  input  wire logic [NMC-1:0]              ioDriven,
  output logic      [NMC-1:0]              ioOut,
  output logic      [NMC-1:0]              ioDriveN,
  input  wire logic                        hsel,
  input  wire logic [31:0]                 haddr,
  input  wire logic [1:0]                  htrans,
  input  wire logic                        hwrite,
  input  wire logic [2:0]                  hsize,
  input  wire logic [31:0]                 hwdata,
  input  wire logic                        hready,
  output logic                             hreadyout,
  output logic                             hresp,
  output logic      [31:0]                 hrdata
);
  import pma_pkg::*;

  localparam int NBLK = NMC / MC_PER_BLK;
  localparam int GB_W = N_IN + 2 * NMC;
  localparam int SY_W = N_IN + N_GCK + 1 + N_OEP + 2 * NMC;

  // ****************************
  // functions
  // ****************************
  function automatic logic ptEval(input logic [PT_MW-1:0] m,
                                  input logic [PT_IN-1:0] x);
    logic r;
    r = 1'b1;
    for (int i = 0; i < PT_IN; i++) begin
      if (m[2*i] && !x[i]) r = 1'b0;
      if (m[2*i+1] && x[i]) r = 1'b0;
    end
    return r;
  endfunction

  // indices above four select no term and read low
  function automatic logic pick(input logic [NUM_PT-1:0] p,
                                input logic [PTI_W-1:0] i);
    return (i < PTI_W'(NUM_PT)) ? p[i] : 1'b0;
  endfunction

  // ****************************
  // pin synchronisers
  // ****************************
  logic [SY_W-1:0]   syncA;
  logic [SY_W-1:0]   syncB;
  logic [N_IN-1:0]   inS;
  logic [N_GCK-1:0]  gckS;
  logic              gclrS;
  logic [N_OEP-1:0]  oepS;
  logic [NMC-1:0]    ioS;
  logic [NMC-1:0]    drvS;

  always_ff @(posedge clock) begin
    if (rst) begin
      syncA <= '0;
      syncB <= '0;
    end else begin
      syncA <= {ioDriven, ioIn, oePins, globalClearLine,
                globalClockLines, inPins};
      syncB <= syncA;
    end
  end

  assign {drvS, ioS, oepS, gclrS, gckS, inS} = syncB;

  // ****************************
  // pin keeper
  // ****************************
  logic [NMC-1:0] kept;
  logic [NMC-1:0] pinVal;

  always_comb begin
    for (int i = 0; i < NMC; i++) begin
      if (!ioDriveN[i]) begin
        pinVal[i] = ioOut[i];
      end else if (drvS[i] || !KEEPER) begin
        pinVal[i] = ioS[i];
      end else begin
        pinVal[i] = kept[i];
      end
    end
  end

  always_ff @(posedge clock) begin
    if (rst) kept <= '0;
    else kept <= pinVal;
  end

  // ****************************
  // global bus and switch matrix
  // ****************************
  logic [NMC-1:0]   fb;
  logic [NMC-1:0]   fold;
  logic [GB_W-1:0]  gbus;
  logic [SW_W-1:0]  blkIn [NBLK];
  logic [NUM_PT-1:0] pt [NMC];

  assign gbus = {fb, pinVal, inS};

  always_comb begin
    for (int b = 0; b < NBLK; b++) begin
      for (int s = 0; s < SW_W; s++) begin
        logic [GBI_W-1:0] idx;
        idx = SW_SEL[(b*SW_W+s)*GBI_W +: GBI_W];
        blkIn[b][s] = (int'(idx) < GB_W) ? gbus[idx] : 1'b0;
      end
    end
  end

  // ****************************
  // product terms
  // ****************************
  // a term with an empty mask reads high, like an unprogrammed AND
  always_comb begin
    for (int m = 0; m < NMC; m++) begin
      logic [PT_IN-1:0] x;
      x = {fold[(m/MC_PER_REG)*MC_PER_REG +: MC_PER_REG],
           blkIn[m/MC_PER_BLK]};
      for (int k = 0; k < NUM_PT; k++) begin
        pt[m][k] = ptEval(PT_CFG[(m*NUM_PT+k)*PT_MW +: PT_MW], x);
      end
    end
  end

  // ****************************
  // sum, xor and storage inputs
  // ****************************
  logic [NMC-1:0] q;
  logic [NMC-1:0] prevClk;
  logic [NMC-1:0] sum;
  logic [NMC-1:0] comb;
  logic [NMC-1:0] dIn;
  logic [NMC-1:0] nxt;
  logic [NMC-1:0] selClk;
  logic [NMC-1:0] ceOk;
  logic [NMC-1:0] arAct;
  logic [NMC-1:0] apAct;
  logic [NMC-1:0] latch;
  logic [NMC-1:0] mcOut;

  always_comb begin
    logic [CFG_W-1:0]  c;
    logic [NUM_PT-1:0] p;
    logic              chain;
    logic              xo;
    logic              k;
    c = '0;
    p = '0;
    chain = 1'b0;
    xo = 1'b0;
    k = 1'b0;
    for (int m = 0; m < NMC; m++) begin
      c = MC_CFG[m*CFG_W +: CFG_W];
      p = pt[m];
      sum[m] = (|(p & c[F_OR_MASK +: NUM_PT]))
               | (c[F_CAS_EN] & chain);
      chain = sum[m];
      unique case (c[F_XOR_MODE +: 2])
        XOR_ONE: xo = 1'b1;
        XOR_PT:  xo = pick(p, c[F_XOR_PT +: PTI_W]);
        default: xo = 1'b0;
      endcase
      comb[m] = sum[m] ^ xo;
      unique case (c[F_D_SEL +: 2])
        D_PT:    dIn[m] = pick(p, c[F_D_PT +: PTI_W]);
        D_PIN:   dIn[m] = pinVal[m];
        default: dIn[m] = comb[m];
      endcase
      k = pick(p, c[F_K_PT +: PTI_W]);
      unique case (c[F_FF_MODE +: 3])
        FF_T:    nxt[m] = q[m] ^ dIn[m];
        FF_JK:   nxt[m] = (dIn[m] & ~q[m]) | (~k & q[m]);
        FF_SR:   nxt[m] = k ? 1'b0 : (dIn[m] | q[m]);
        default: nxt[m] = dIn[m];
      endcase
      latch[m] = (c[F_FF_MODE +: 3] == FF_LATCH);
      if (c[F_CLK_SEL +: 2] == CLK_PT) begin
        selClk[m] = pick(p, c[F_CLK_PT +: PTI_W]);
        ceOk[m] = 1'b1;
      end else begin
        selClk[m] = gckS[c[F_CLK_SEL +: 2]];
        ceOk[m] = !c[F_CE_EN] || pick(p, c[F_CE_PT +: PTI_W]);
      end
      unique case (c[F_AR_SEL +: 2])
        AR_GCLR: arAct[m] = gclrS;
        AR_PT:   arAct[m] = pick(p, c[F_AR_PT +: PTI_W]);
        AR_BOTH: arAct[m] = gclrS | pick(p, c[F_AR_PT +: PTI_W]);
        AR_OFF:  arAct[m] = 1'b0;
      endcase
      apAct[m] = c[F_AP_EN] & pick(p, c[F_AP_PT +: PTI_W]);
      fold[m] = ~pick(p, c[F_FOLD_PT +: PTI_W]);
      mcOut[m] = c[F_OUT_REG] ? q[m] : comb[m];
      fb[m] = c[F_FB_REG] ? q[m] : comb[m];
    end
  end

  // ****************************
  // storage elements
  // ****************************
  // clear and preset act at the next system edge; clear beats preset
  always_ff @(posedge clock) begin
    if (rst) begin
      q <= '0;
      prevClk <= '0;
    end else begin
      prevClk <= selClk;
      for (int m = 0; m < NMC; m++) begin
        if (arAct[m]) begin
          q[m] <= 1'b0;
        end else if (apAct[m]) begin
          q[m] <= 1'b1;
        end else if (latch[m]) begin
          if (selClk[m]) q[m] <= dIn[m];
        end else if (selClk[m] && !prevClk[m] && ceOk[m]) begin
          q[m] <= nxt[m];
        end
      end
    end
  end

  // ****************************
  // output enable
  // ****************************
  logic [NMC-1:0] oe;

  always_comb begin
    for (int m = 0; m < NMC; m++) begin
      logic [MCI_W-1:0] idx;
      logic             s;
      idx = MC_CFG[m*CFG_W+F_OE_IDX +: MCI_W];
      s = 1'b0;
      unique case (MC_CFG[m*CFG_W+F_OE_SRC +: 2])
        OE_PIN:  s = oepS[idx[0]];
        OE_IO:   s = (int'(idx) < NMC) ? pinVal[idx] : 1'b0;
        OE_MC:   s = (int'(idx) < NMC) ? mcOut[idx] : 1'b0;
        default: s = 1'b0;
      endcase
      s = s ^ MC_CFG[m*CFG_W+F_OE_INV];
      unique case (MC_CFG[m*CFG_W+F_IO_MODE +: 2])
        IO_OUT:   oe[m] = 1'b1;
        IO_BIDIR: oe[m] = s;
        default:  oe[m] = 1'b0;
      endcase
    end
  end

  // pins lag the logic by one edge so they leave from flip-flops
  always_ff @(posedge clock) begin
    if (rst) begin
      ioOut <= '0;
      ioDriveN <= '1;
    end else begin
      ioOut <= mcOut;
      ioDriveN <= ~oe;
    end
  end

  // ****************************
  // register bus slave
  // ****************************
  logic             aWr;
  logic             aRd;
  logic [7:0]       aAddr;
  logic             rdWait;
  logic [15:0]      sign;
  logic             fuse;
  logic [MCI_W-1:0] cidx;
  logic [CFG_W-1:0] cfgWord;
  logic [63:0]      qPad;
  logic [31:0]      rdMux;

  // reads take one wait cycle so a preceding write is always seen
  assign hreadyout = !(aRd && !rdWait);
  assign hresp = 1'b0;
  assign qPad = 64'(q);
  assign cfgWord = (int'(cidx) < NMC) ? MC_CFG[cidx*CFG_W +: CFG_W] : '0;

  always_ff @(posedge clock) begin
    if (rst) begin
      aWr <= 1'b0;
      aRd <= 1'b0;
      aAddr <= '0;
    end else if (hready) begin
      aWr <= hsel && htrans[1] && hwrite;
      aRd <= hsel && htrans[1] && !hwrite;
      aAddr <= haddr[7:0];
    end
  end

  always_ff @(posedge clock) begin
    if (rst) rdWait <= 1'b0;
    else rdWait <= aRd && !rdWait;
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      sign <= SIGN_RST;
      fuse <= 1'b0;
      cidx <= '0;
    end else if (aWr) begin
      unique case (aAddr)
        R_SIGN:  sign <= hwdata[15:0];
        R_FUSE:  fuse <= fuse | hwdata[0];
        R_CIDX:  cidx <= hwdata[MCI_W-1:0];
        default: ;
      endcase
    end
  end

  always_comb begin
    unique case (aAddr)
      R_SIGN:  rdMux = {16'h0000, sign};
      R_FUSE:  rdMux = {31'h0, fuse};
      R_CIDX:  rdMux = 32'(cidx);
      R_CLO:   rdMux = fuse ? 32'h00000000 : cfgWord[31:0];
      R_CHI:   rdMux = fuse ? 32'h00000000 : cfgWord[63:32];
      R_QLO:   rdMux = qPad[31:0];
      R_QHI:   rdMux = qPad[63:32];
      default: rdMux = 32'h00000000;
    endcase
  end

  always_ff @(posedge clock) begin
    if (rst) hrdata <= '0;
    else if (aRd && !rdWait) hrdata <= rdMux;
  end
endmodule

// ===== tb/pma_board.sv
`timescale 1ns/1ns
// ****************************
// board logic on the i/o pins
// ****************************
module pma_board #(
  parameter int N = 64
) (
  input  wire logic         clock,
  input  wire logic [N-1:0] ioOut,
  input  wire logic [N-1:0] ioDriveN,
  input  wire logic [N-1:0] drvVal,
  input  wire logic [N-1:0] drvEn,
  output logic      [N-1:0] ioIn,
  output logic      [N-1:0] ioDriven
);
  logic [N-1:0] last = '0;
  // no pull on the board: a floating line flips every cycle
  assign ioIn = (~ioDriveN & ioOut) | (ioDriveN & drvEn & drvVal)
              | (ioDriveN & ~drvEn & ~last);
  assign ioDriven = drvEn;
  always_ff @(posedge clock) begin
    last <= ioIn;
  end
endmodule

// ===== tb/pma_macrocell_array_props.sv
`timescale 1ns/1ns
// ****************************
// port checker
// ****************************
module pma_macrocell_array_props #(
  parameter int NMC = 64
) (
  input wire logic           clock,
  input wire logic           rst,
  input wire logic [3:0]     inPins,
  input wire logic [2:0]     globalClockLines,
  input wire logic           globalClearLine,
  input wire logic [1:0]     oePins,
  input wire logic [NMC-1:0] ioOut,
  input wire logic [NMC-1:0] ioDriveN,
  input wire logic           hsel,
  input wire logic [1:0]     htrans,
  input wire logic           hwrite,
  input wire logic           hready,
  input wire logic           hreadyout,
  input wire logic           hresp,
  input wire logic [31:0]    hrdata
);
  logic [3:0] runCnt;
  logic [3:0] gckAge;
  logic [3:0] clrAge;
  logic       gckPrev;
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  always_ff @(posedge clock) begin
    if (rst) runCnt <= 4'h0;
    else if (runCnt != 4'hf) runCnt <= runCnt + 4'h1;
  end
  always_ff @(posedge clock) begin
    gckPrev <= globalClockLines[0];
    if (rst) gckAge <= 4'hf;
    else if (globalClockLines[0] && !gckPrev) gckAge <= 4'h0;
    else if (gckAge != 4'hf) gckAge <= gckAge + 4'h1;
  end
  always_ff @(posedge clock) begin
    if (rst || globalClearLine) clrAge <= 4'h0;
    else if (clrAge != 4'hf) clrAge <= clrAge + 4'h1;
  end
  AST_WR_NOWAIT:
    assert property (hsel && htrans[1] && hwrite && hready |=> hreadyout)
    else $error("write data phase waited");
  AST_RD_WAIT:
    assert property (hsel && htrans[1] && !hwrite && hready
                     |=> !hreadyout ##1 hreadyout)
    else $error("read wait state wrong");
  AST_HRESP_OKAY:
    assert property (!hresp) else $error("response not okay");
  AST_RDATA_HOLD:
    assert property ($changed(hrdata) |-> $past(!hreadyout))
    else $error("read data moved outside a read");
  AST_RST_OUT:
    assert property (disable iff (1'b0) rst |=> &ioDriveN && hreadyout)
    else $error("outputs not idle after reset");
  AST_POLARITY:
    assert property (runCnt > 4'h4 |-> ioOut[0] ==
                     !($past(inPins[0], 3) | $past(inPins[1], 3)))
    else $error("inverted sum wrong");
  AST_OE_PIN:
    assert property (runCnt > 4'h4 |-> ioDriveN[0] == !$past(oePins[0], 3))
    else $error("drive enable not from enable pin");
  AST_IN_ONLY:
    assert property (ioDriveN[2]) else $error("input-only pin driven");
  AST_REG_EDGE:
    assert property ($changed(ioOut[1]) |-> gckAge < 4'h7 || clrAge < 4'h7)
    else $error("register moved without clock");
  AST_CLR:
    assert property (globalClearLine [*3] |-> ##[1:4] !ioOut[1])
    else $error("global clear ignored");
endmodule
bind pma_macrocell_array pma_macrocell_array_props #(.NMC(NMC)) u_props (
  .clock(clock), .rst(rst), .inPins(inPins),
  .globalClockLines(globalClockLines), .globalClearLine(globalClearLine),
  .oePins(oePins), .ioOut(ioOut), .ioDriveN(ioDriveN), .hsel(hsel),
  .htrans(htrans), .hwrite(hwrite), .hready(hready),
  .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata));

// ===== tb/test_programmable_macrocell_array.sv
`timescale 1ns/1ns
module test_programmable_macrocell_array;
  import pma_pkg::*;
  localparam int MCW = NUM_MC * CFG_W;
  localparam int PTW = NUM_MC * NUM_PT * PT_MW;
  localparam int SWW = NUM_MC / MC_PER_BLK * SW_W * GBI_W;
  // ****************************
  // cells 0..6: polarity, gated d, pin d, toggle, xor, cascade, feedback
  // ****************************
  localparam logic [63:0] C0 = 64'h3 | (64'(XOR_ONE) << F_XOR_MODE)
    | (64'(IO_BIDIR) << F_IO_MODE) | (64'(OE_PIN) << F_OE_SRC);
  localparam logic [63:0] C1 = 64'h1 | (64'h1 << F_CE_EN)
    | (64'h1 << F_CE_PT) | (64'(AR_GCLR) << F_AR_SEL)
    | (64'h1 << F_OUT_REG) | (64'(IO_OUT) << F_IO_MODE)
    | (64'h1 << F_OE_IDX) | (64'h1 << F_OE_INV);
  localparam logic [63:0] C2 = (64'(D_PIN) << F_D_SEL) | (64'h1 << F_CLK_SEL);
  localparam logic [63:0] C3 = 64'h1 | (64'(FF_T) << F_FF_MODE)
    | (64'h2 << F_CLK_SEL);
  localparam logic [63:0] C4 = 64'h1 | (64'(XOR_PT) << F_XOR_MODE)
    | (64'h1 << F_XOR_PT) | (64'h1 << F_AP_EN) | (64'h2 << F_AP_PT)
    | (64'h1 << F_FB_REG) | (64'(IO_OUT) << F_IO_MODE)
    | (64'h1 << F_FOLD_PT);
  localparam logic [63:0] C5 = 64'h1 | (64'h1 << F_CAS_EN)
    | (64'(IO_OUT) << F_IO_MODE);
  localparam logic [63:0] C6 = 64'h1 | (64'(IO_OUT) << F_IO_MODE);
  localparam logic [MCW-1:0] MCC = MCW'({C6, C5, C4, C3, C2, C1, C0});
  // bit (cell*5+term)*88 + 2*input asks for that input high
  localparam logic [PTW-1:0] PTC = (PTW'(1) << 0) | (PTW'(1) << 90)
    | (PTW'(1) << 444) | (PTW'(1) << 534) | (PTW'(1) << 1320)
    | (PTW'(1) << 1760) | (PTW'(1) << 1850) | (PTW'(1) << 1940)
    | (PTW'(1) << 2280) | (PTW'(1) << 2648);
  // slot 4 carries feedback of cell 4
  localparam logic [SWW-1:0] SWS = SWW'(40'h48_0302_0100);
  logic        clock = 1'b0;
  logic        rst = 1'b1;
  logic [3:0]  inPins = '0;
  logic [2:0]  globalClockLines = '0;
  logic        globalClearLine = 1'b0;
  logic [1:0]  oePins = '0;
  logic [63:0] drvVal = '0;
  logic [63:0] drvEn = '0;
  logic        hsel = 1'b0;
  logic [31:0] haddr = '0;
  logic [1:0]  htrans = '0;
  logic        hwrite = 1'b0;
  logic [2:0]  hsize = 3'h2;
  logic [31:0] hwdata = '0;
  wire  [63:0] ioIn, ioDriven, ioOut, ioDriveN;
  wire         hreadyout, hresp;
  wire  [31:0] hrdata;
  int          bad_count = 0;
  int          compares = 0;
  always #20 clock = ~clock;
  pma_macrocell_array #(.MC_CFG(MCC), .PT_CFG(PTC), .SW_SEL(SWS),
    .KEEPER(1'b1)) dut (
    .clock(clock), .rst(rst), .inPins(inPins),
    .globalClockLines(globalClockLines), .globalClearLine(globalClearLine),
    .oePins(oePins), .ioIn(ioIn), .ioDriven(ioDriven), .ioOut(ioOut),
    .ioDriveN(ioDriveN), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata));
  pma_board board (
    .clock(clock), .ioOut(ioOut), .ioDriveN(ioDriveN), .drvVal(drvVal),
    .drvEn(drvEn), .ioIn(ioIn), .ioDriven(ioDriven));
  task cyc(input int n);
    repeat (n) @(posedge clock);
  endtask
  task chk(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e) begin
      bad_count++;
      $display("MISMATCH t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  // ready is looked at on the falling edge, half a cycle before the rising edge, so no race with the slave
  task ahb(input logic w, input logic [7:0] a, input logic [31:0] wd,
           output logic [31:0] rd);
    logic r;
    @(posedge clock);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    do begin @(negedge clock); r = hreadyout; @(posedge clock); end
    while (r !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do begin
      @(negedge clock);
      r = hreadyout;
      rd = hrdata;
      @(posedge clock);
    end while (r !== 1'b1);
  endtask
  task pulse(input int k);
    globalClockLines[k] <= 1'b1;
    cyc(3);
    globalClockLines[k] <= 1'b0;
    cyc(4);
  endtask
  task t_regs;
    logic [31:0] d;
    ahb(1'b1, R_SIGN, 32'h0000_a5c3, d);
    ahb(1'b0, R_SIGN, '0, d);
    chk(d, 32'h0000_a5c3);
    ahb(1'b1, R_CIDX, 32'h1, d);
    ahb(1'b0, R_CLO, '0, d);
    chk(d, C1[31:0]);
    ahb(1'b0, R_CHI, '0, d);
    chk(d, C1[63:32]);
    ahb(1'b1, 8'h1c, 32'hffff_ffff, d);
    ahb(1'b0, 8'h1c, '0, d);
    chk(d, 32'h0);
  endtask
  task t_comb;
    for (int i = 0; i < 4; i++) begin
      inPins[1:0] <= i[1:0];
      oePins[0] <= i[0];
      cyc(5);
      chk(32'(ioOut[0]), 32'(i == 0));
      chk(32'(ioDriveN[0]), 32'(!i[0]));
      chk(32'(ioOut[4]), 32'(i[0] ^ i[1]));
      chk(32'(ioOut[5]), 32'(i[0] | !i[1]));
    end
  endtask
  task t_reg;
    inPins[3:2] <= 2'b11;
    cyc(3);
    pulse(0);
    chk(32'(ioOut[1]), 32'h1);
    inPins[3:2] <= 2'b00;
    cyc(3);
    pulse(0);
    chk(32'(ioOut[1]), 32'h1);
    inPins[3] <= 1'b1;
    cyc(3);
    pulse(0);
    chk(32'(ioOut[1]), 32'h0);
    inPins[2] <= 1'b1;
    cyc(3);
    pulse(1);
    chk(32'(ioOut[1]), 32'h0);
    pulse(0);
    chk(32'(ioOut[1]), 32'h1);
    globalClearLine <= 1'b1;
    cyc(4);
    globalClearLine <= 1'b0;
    cyc(2);
    chk(32'(ioOut[1]), 32'h0);
  endtask
  task t_pin;
    logic [31:0] d;
    drvEn[2] <= 1'b1;
    drvVal[2] <= 1'b1;
    cyc(3);
    pulse(1);
    ahb(1'b0, R_QLO, '0, d);
    chk(32'(d[2]), 32'h1);
    chk(32'(ioDriveN[2]), 32'h1);
    drvEn[2] <= 1'b0;
    cyc(3);
    pulse(1);
    ahb(1'b0, R_QLO, '0, d);
    chk(32'(d[2]), 32'h1);
    drvEn[2] <= 1'b1;
    drvVal[2] <= 1'b0;
    inPins[0] <= 1'b1;
    cyc(3);
    pulse(1);
    pulse(2);
    ahb(1'b0, R_QLO, '0, d);
    chk({30'h0, d[3:2]}, 32'h2);
    pulse(2);
    ahb(1'b0, R_QLO, '0, d);
    chk(32'(d[3]), 32'h0);
  endtask
  task t_fb;
    inPins <= 4'b1011;
    cyc(3);
    pulse(0);
    chk(32'(ioOut[6]), 32'h0);
    inPins[2] <= 1'b1;
    cyc(5);
    chk(32'(ioOut[6]), 32'h1);
  endtask
  task t_fuse;
    logic [31:0] d;
    ahb(1'b1, R_FUSE, 32'h1, d);
    ahb(1'b1, R_FUSE, 32'h0, d);
    ahb(1'b0, R_FUSE, '0, d);
    chk(d, 32'h1);
    ahb(1'b0, R_CLO, '0, d);
    chk(d, 32'h0);
    ahb(1'b0, R_SIGN, '0, d);
    chk(d, 32'h0000_a5c3);
  endtask
  task stop_test;
    $display("mismatches %0d compares %0d", bad_count, compares);
    if (bad_count == 0 && compares > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  initial begin
    cyc(16);
    rst <= 1'b0;
    cyc(3);
    t_regs;
    t_comb;
    t_reg;
    t_pin;
    t_fb;
    t_fuse;
    stop_test;
  end
  initial begin
    cyc(20000);
    bad_count++;
    $display("MISMATCH t=%0t watchdog expired", $time);
    stop_test;
  end
endmodule
